// file: pkg/iob_pkg.sv
// I/O register bank constants: offsets, field masks, reset values, access kinds.
// Assumes one core clock domain and a core that issues at most one access a cycle.
package iob_pkg;

  // Access kinds issued by the core
  typedef enum logic [2:0] {
    IOB_READ       = 3'h0,  // Whole-byte read
    IOB_WRITE      = 3'h1,  // Whole-byte write
    IOB_SET_BIT    = 3'h2,  // set_io_bit_instr
    IOB_CLEAR_BIT  = 3'h3,  // clear_io_bit_instr
    IOB_SKIP_HIGH  = 3'h4,  // skip_if_io_bit_high
    IOB_SKIP_LOW   = 3'h5   // skip_if_io_bit_low
  } iob_kind_e;

  // Address geometry
  localparam int unsigned IOB_IO_WORDS    = 64;     // I/O address slots
  localparam logic [6:0]  IOB_DATA_OFFSET = 7'h20;  // Data space alias offset
  localparam logic [6:0]  IOB_DATA_END    = 7'h60;  // First data address past the alias
  localparam logic [5:0]  IOB_BIT_LAST    = 6'h1f;  // Last bit-accessible address

  // Register offsets in I/O space
  localparam logic [5:0] IOB_PORT_B_INPUT_LEVELS    = 6'h16;
  localparam logic [5:0] IOB_PORT_B_DIRECTION       = 6'h17;
  localparam logic [5:0] IOB_PORT_B_OUTPUT_LATCH    = 6'h18;
  localparam logic [5:0] IOB_PORT_A_INPUT_LEVELS    = 6'h19;
  localparam logic [5:0] IOB_PORT_A_DIRECTION       = 6'h1a;
  localparam logic [5:0] IOB_PORT_A_OUTPUT_LATCH    = 6'h1b;
  localparam logic [5:0] IOB_NVM_DATA_CONTROL       = 6'h1c;
  localparam logic [5:0] IOB_NVM_DATA_BYTE          = 6'h1d;
  localparam logic [5:0] IOB_NVM_ADDRESS_LOW        = 6'h1e;
  localparam logic [5:0] IOB_NVM_ADDRESS_HIGH       = 6'h1f;
  localparam logic [5:0] IOB_DEBUG_LINK_DATA        = 6'h20;
  localparam logic [5:0] IOB_WATCHDOG_CONTROL       = 6'h21;
  localparam logic [5:0] IOB_PIN_CHANGE_MASK_HIGH   = 6'h22;
  localparam logic [5:0] IOB_PIN_CHANGE_MASK_LOW    = 6'h23;
  localparam logic [5:0] IOB_DEAD_TIME_VALUES       = 6'h24;
  localparam logic [5:0] IOB_FAST_TIMER_HIGH_BITS   = 6'h25;
  localparam logic [5:0] IOB_FAST_TIMER_CONTROL_D   = 6'h26;
  localparam logic [5:0] IOB_FAST_TIMER_CONTROL_C   = 6'h27;
  localparam logic [5:0] IOB_CLOCK_PRESCALE         = 6'h28;
  localparam logic [5:0] IOB_PLL_CONTROL_STATUS     = 6'h29;
  localparam logic [5:0] IOB_FAST_TIMER_COMPARE_D   = 6'h2a;
  localparam logic [5:0] IOB_FAST_TIMER_COMPARE_C   = 6'h2b;
  localparam logic [5:0] IOB_FAST_TIMER_COMPARE_B   = 6'h2c;
  localparam logic [5:0] IOB_FAST_TIMER_COMPARE_A   = 6'h2d;
  localparam logic [5:0] IOB_FAST_TIMER_COUNT       = 6'h2e;
  localparam logic [5:0] IOB_FAST_TIMER_CONTROL_B   = 6'h2f;
  localparam logic [5:0] IOB_FAST_TIMER_CONTROL_A   = 6'h30;
  localparam logic [5:0] IOB_RC_OSC_TRIM            = 6'h31;
  localparam logic [5:0] IOB_BASE_TIMER_COUNT_LOW   = 6'h32;
  localparam logic [5:0] IOB_BASE_TIMER_CONTROL_B   = 6'h33;
  localparam logic [5:0] IOB_RESET_CAUSE_FLAGS      = 6'h34;
  localparam logic [5:0] IOB_CORE_SLEEP_CONTROL     = 6'h35;
  localparam logic [5:0] IOB_POWER_REDUCTION        = 6'h36;
  localparam logic [5:0] IOB_SELF_PROGRAM_CONTROL   = 6'h37;
  localparam logic [5:0] IOB_TIMER_INTERRUPT_FLAGS  = 6'h38;
  localparam logic [5:0] IOB_TIMER_INTERRUPT_MASK   = 6'h39;
  localparam logic [5:0] IOB_EXTERNAL_INTERRUPT_FLAGS = 6'h3a;
  localparam logic [5:0] IOB_EXTERNAL_INTERRUPT_MASK  = 6'h3b;
  localparam logic [5:0] IOB_UNUSED_SLOT            = 6'h3c;
  localparam logic [5:0] IOB_STACK_POINTER_LOW      = 6'h3d;
  localparam logic [5:0] IOB_STACK_POINTER_HIGH     = 6'h3e;
  localparam logic [5:0] IOB_CORE_STATUS_FLAGS      = 6'h3f;

  // Implemented-bit masks for partly populated registers
  localparam logic [7:0] IOB_MASK_FULL      = 8'hff;
  localparam logic [7:0] IOB_MASK_NONE      = 8'h00;
  localparam logic [7:0] IOB_MASK_NVM_CTRL  = 8'h3f;
  localparam logic [7:0] IOB_MASK_NVM_ADRH  = 8'h01;
  localparam logic [7:0] IOB_MASK_FAST_TIMER_HIGH_BITS      = 8'h03;
  localparam logic [7:0] IOB_MASK_CLOCK_PRESCALE     = 8'h8f;
  localparam logic [7:0] IOB_MASK_PLL       = 8'h87;
  localparam logic [7:0] IOB_MASK_TCB0      = 8'h1f;
  localparam logic [7:0] IOB_MASK_RSTCAUSE  = 8'h0f;
  localparam logic [7:0] IOB_MASK_SLEEP     = 8'h7b;
  localparam logic [7:0] IOB_MASK_PRR       = 8'h0f;
  localparam logic [7:0] IOB_MASK_SPM       = 8'h3f;
  localparam logic [7:0] IOB_MASK_EXTERNAL_INTERRUPT_FLAGS      = 8'he0;
  localparam logic [7:0] IOB_MASK_EXTERNAL_INTERRUPT_MASK     = 8'hf0;
  localparam logic [7:0] IOB_MASK_SPH       = 8'h07;

  // Write-one-to-clear flag masks
  localparam logic [7:0] IOB_W1C_TIMER_INTERRUPT_FLAGS       = 8'hff;
  localparam logic [7:0] IOB_W1C_EXTERNAL_INTERRUPT_FLAGS       = 8'he0;
  localparam logic [7:0] IOB_W1C_WDT        = 8'h80;
  localparam int unsigned IOB_EXTERNAL_INTERRUPT_FLAGS_LSB      = 5;  // Lowest external flag bit
  localparam int unsigned IOB_WDT_FLAG_BIT  = 7;  // Watchdog flag position

  // Value of every register after reset
  localparam logic [7:0] IOB_RESET_BYTE     = 8'h00;

endpackage : iob_pkg

// file: hw/iob_io_bank.sv
// I/O register bank with whole-byte and single-bit access from the core.
// Assumes the core presents one access per cycle, synchronous to clk, and
// that peripherals read their registers from the flat image output.
//
// Contract
// RL1 - Bit set/clear only at I/O 0x00..0x1F
// RL2 - Skip tests on low-range register bits
// RL3 - Writing one clears flags; zero keeps
// RL4 - Bit op touches only the addressed bit
// RL5 - Software writes reserved bits as zero
// RL6 - Software never writes reserved addresses
// RL7 - Data space alias at I/O plus 0x20
`timescale 1ns/100ps

module iob_io_bank #(
  parameter int unsigned DATA_W = 8  // Register width
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   acc_valid,
  input  iob_pkg::iob_kind_e          acc_kind,
  input  wire logic                   acc_dspace,
  input  wire logic [6:0]             acc_addr,
  input  wire logic [2:0]             acc_bit,
  input  wire logic [DATA_W-1:0]      acc_wdata,
  input  wire logic [DATA_W-1:0]      port_a_pins,
  input  wire logic [DATA_W-1:0]      port_b_pins,
  input  wire logic [DATA_W-1:0]      timer_flag_set,
  input  wire logic [2:0]             ext_flag_set,
  input  wire logic                   wdog_flag_set,
  output logic                        resp_valid_q,
  output logic [DATA_W-1:0]           rd_data_q,
  output logic                        skip_q,
  output logic                        ignored_q,
  output logic [63:0][DATA_W-1:0]     io_image_q
);

  // Bits that exist and can be written at an I/O address
  function automatic logic [7:0] impl_mask(input logic [5:0] a);
    logic [7:0] m;
    m = iob_pkg::IOB_MASK_FULL;
    if (a < iob_pkg::IOB_PORT_B_INPUT_LEVELS) begin
      m = iob_pkg::IOB_MASK_NONE;  // Nothing mapped below the table
    end
    case (a)
      iob_pkg::IOB_PORT_B_INPUT_LEVELS:      m = iob_pkg::IOB_MASK_NONE;
      iob_pkg::IOB_PORT_A_INPUT_LEVELS:      m = iob_pkg::IOB_MASK_NONE;
      iob_pkg::IOB_NVM_DATA_CONTROL:         m = iob_pkg::IOB_MASK_NVM_CTRL;
      iob_pkg::IOB_NVM_ADDRESS_HIGH:         m = iob_pkg::IOB_MASK_NVM_ADRH;
      iob_pkg::IOB_FAST_TIMER_HIGH_BITS:     m = iob_pkg::IOB_MASK_FAST_TIMER_HIGH_BITS;
      iob_pkg::IOB_CLOCK_PRESCALE:           m = iob_pkg::IOB_MASK_CLOCK_PRESCALE;
      iob_pkg::IOB_PLL_CONTROL_STATUS:       m = iob_pkg::IOB_MASK_PLL;
      iob_pkg::IOB_BASE_TIMER_CONTROL_B:     m = iob_pkg::IOB_MASK_TCB0;
      iob_pkg::IOB_RESET_CAUSE_FLAGS:        m = iob_pkg::IOB_MASK_RSTCAUSE;
      iob_pkg::IOB_CORE_SLEEP_CONTROL:       m = iob_pkg::IOB_MASK_SLEEP;
      iob_pkg::IOB_POWER_REDUCTION:          m = iob_pkg::IOB_MASK_PRR;
      iob_pkg::IOB_SELF_PROGRAM_CONTROL:     m = iob_pkg::IOB_MASK_SPM;
      iob_pkg::IOB_EXTERNAL_INTERRUPT_FLAGS: m = iob_pkg::IOB_MASK_EXTERNAL_INTERRUPT_FLAGS;
      iob_pkg::IOB_EXTERNAL_INTERRUPT_MASK:  m = iob_pkg::IOB_MASK_EXTERNAL_INTERRUPT_MASK;
      iob_pkg::IOB_UNUSED_SLOT:              m = iob_pkg::IOB_MASK_NONE;  // [RL6]
      iob_pkg::IOB_STACK_POINTER_HIGH:       m = iob_pkg::IOB_MASK_SPH;
      default:                               m = m;
    endcase
    return m;
  endfunction : impl_mask

  // Flag bits that clear on a written one
  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    logic [7:0] m;
    m = iob_pkg::IOB_MASK_NONE;
    case (a)
      iob_pkg::IOB_TIMER_INTERRUPT_FLAGS:    m = iob_pkg::IOB_W1C_TIMER_INTERRUPT_FLAGS;
      iob_pkg::IOB_EXTERNAL_INTERRUPT_FLAGS: m = iob_pkg::IOB_W1C_EXTERNAL_INTERRUPT_FLAGS;
      iob_pkg::IOB_WATCHDOG_CONTROL:         m = iob_pkg::IOB_W1C_WDT;
      default:                               m = iob_pkg::IOB_MASK_NONE;
    endcase
    return m;
  endfunction : w1c_mask

  // Decoded access
  logic [6:0]        alias_diff;  // Data address minus alias offset
  logic [5:0]        io_a;        // Effective I/O address
  logic              in_space;    // Address lands in I/O space
  logic              in_bit_rng;  // Address is bit-accessible
  logic              is_bit_op;   // Set or clear bit
  logic              is_test;     // Skip test
  logic              do_write;    // Register update this cycle
  logic              refused;     // Access has no effect
  logic [7:0]        bit_sel;     // One-hot addressed bit
  logic [7:0]        wr_sel;      // Bits the access targets
  logic [7:0]        wr_val;      // Value offered on targeted bits
  logic [7:0]        cur_byte;    // Current register contents
  logic [63:0][7:0]  image_d;     // Next register image

  // Address and kind decode
  always_comb begin
    alias_diff = acc_addr - iob_pkg::IOB_DATA_OFFSET;
    if (acc_dspace) begin
      // Same register through the data space alias [RL7]
      in_space = (acc_addr >= iob_pkg::IOB_DATA_OFFSET) && (acc_addr < iob_pkg::IOB_DATA_END);
      io_a     = alias_diff[5:0];
    end else begin
      in_space = ~acc_addr[6];
      io_a     = acc_addr[5:0];
    end
    in_bit_rng = io_a <= iob_pkg::IOB_BIT_LAST;  // [RL1]
    is_bit_op  = (acc_kind == iob_pkg::IOB_SET_BIT) || (acc_kind == iob_pkg::IOB_CLEAR_BIT);
    is_test    = (acc_kind == iob_pkg::IOB_SKIP_HIGH) || (acc_kind == iob_pkg::IOB_SKIP_LOW);
    // Bit ops and tests outside the low range do nothing [RL1] [RL2]
    refused    = ~in_space || ((is_bit_op || is_test) && ~in_bit_rng);
    do_write   = acc_valid && ~refused && (is_bit_op || (acc_kind == iob_pkg::IOB_WRITE));
    bit_sel    = 8'h01 << acc_bit;
    cur_byte   = io_image_q[io_a];
  end

  // Targeted bits and offered value for the write
  always_comb begin
    if (is_bit_op) begin
      wr_sel = bit_sel;  // Only the addressed bit [RL4]
      wr_val = (acc_kind == iob_pkg::IOB_SET_BIT) ? 8'hff : 8'h00;
    end else begin
      wr_sel = 8'hff;
      wr_val = acc_wdata;
    end
  end

  // Next image: software write, then hardware sets and pin sampling
  always_comb begin
    logic [7:0] plain;
    logic [7:0] clr;
    logic [7:0] nb;
    plain   = 8'h00;
    clr     = 8'h00;
    nb      = 8'h00;
    image_d = io_image_q;
    if (do_write) begin
      // Reserved bits are masked, so stray ones never stick [RL5]
      plain = wr_sel & impl_mask(io_a) & ~w1c_mask(io_a);
      // A one clears a flag, a zero leaves it [RL3]
      clr   = wr_sel & w1c_mask(io_a) & wr_val;  // [RL4]
      nb    = (cur_byte & ~plain) | (wr_val & plain);
      image_d[io_a] = nb & ~clr;
    end
    // Hardware set wins over a same-cycle clear
    image_d[iob_pkg::IOB_TIMER_INTERRUPT_FLAGS] =
      image_d[iob_pkg::IOB_TIMER_INTERRUPT_FLAGS] | timer_flag_set;
    image_d[iob_pkg::IOB_EXTERNAL_INTERRUPT_FLAGS][7:iob_pkg::IOB_EXTERNAL_INTERRUPT_FLAGS_LSB] =
      image_d[iob_pkg::IOB_EXTERNAL_INTERRUPT_FLAGS][7:iob_pkg::IOB_EXTERNAL_INTERRUPT_FLAGS_LSB] | ext_flag_set;
    image_d[iob_pkg::IOB_WATCHDOG_CONTROL][iob_pkg::IOB_WDT_FLAG_BIT] =
      image_d[iob_pkg::IOB_WATCHDOG_CONTROL][iob_pkg::IOB_WDT_FLAG_BIT] | wdog_flag_set;
    // Input level registers follow the pins, one cycle behind
    image_d[iob_pkg::IOB_PORT_A_INPUT_LEVELS] = port_a_pins;
    image_d[iob_pkg::IOB_PORT_B_INPUT_LEVELS] = port_b_pins;
  end

  // Register image storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_image_q <= {iob_pkg::IOB_IO_WORDS{iob_pkg::IOB_RESET_BYTE}};
    end else begin
      io_image_q <= image_d;
    end
  end

  // Response: read data is the value before this access's write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid_q <= 1'b0;
      rd_data_q    <= 8'h00;
      skip_q       <= 1'b0;
      ignored_q    <= 1'b0;
    end else begin
      resp_valid_q <= acc_valid;
      ignored_q    <= acc_valid && refused;
      rd_data_q    <= (acc_valid && ~refused) ? cur_byte : 8'h00;
      if (acc_valid && ~refused && is_test) begin
        // Skip when the bit matches the tested level [RL2]
        skip_q <= (acc_kind == iob_pkg::IOB_SKIP_HIGH) ? cur_byte[acc_bit] : ~cur_byte[acc_bit];
      end else begin
        skip_q <= 1'b0;
      end
    end
  end

endmodule : iob_io_bank

// file: testbench/iob_io_bank_chk.sv
// Checker for the I/O bank: bit access, skip tests, flags, alias.
// Assumes bind to iob_io_bank, one clock, async active-low reset.
`timescale 1ns/100ps
module iob_io_bank_chk #(
  parameter int unsigned DATA_W = 8  // Register width
) (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  acc_valid,
  input iob_pkg::iob_kind_e         acc_kind,
  input wire logic                  acc_dspace,
  input wire logic [6:0]            acc_addr,
  input wire logic [2:0]            acc_bit,
  input wire logic [DATA_W-1:0]     acc_wdata,
  input wire logic [DATA_W-1:0]     timer_flag_set,
  input wire logic                  resp_valid_q,
  input wire logic [DATA_W-1:0]     rd_data_q,
  input wire logic                  skip_q,
  input wire logic                  ignored_q,
  input wire logic [63:0][DATA_W-1:0] io_image_q
);
  logic [6:0] idx;  // I/O index of request
  logic       ok;   // Inside the space
  logic       lo;   // Bit-accessible
  logic       bop;  // Set or clear
  logic       pl;   // Plain full register
  // Decode once; data addresses fold onto I/O
  assign idx = acc_dspace ? acc_addr - 7'h20 : acc_addr;
  assign ok  = acc_dspace ? (acc_addr >= 7'h20 && acc_addr < 7'h60) : !acc_addr[6];
  assign lo  = ok && idx <= 7'h1f;
  assign bop = acc_kind == iob_pkg::IOB_SET_BIT || acc_kind == iob_pkg::IOB_CLEAR_BIT;
  // Pins and flags excluded: hardware may move them
  assign pl  = idx inside {7'h17, 7'h18, 7'h1a, 7'h1b, 7'h1d, 7'h1e};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  bit_refuse_a: assert property (acc_valid && bop && !lo |=> ignored_q && resp_valid_q)
    else $error("bit op outside low range accepted");
  set_bit_a: assert property (acc_valid && acc_kind == iob_pkg::IOB_SET_BIT && lo && pl
    |=> io_image_q[$past(idx[5:0])][$past(acc_bit)]) else $error("bit not set");
  clr_bit_a: assert property (acc_valid && acc_kind == iob_pkg::IOB_CLEAR_BIT && lo && pl
    |=> !io_image_q[$past(idx[5:0])][$past(acc_bit)]) else $error("bit not cleared");
  bit_only_a: assert property (acc_valid && bop && lo && pl |=> ((io_image_q[$past(idx[5:0])]
    ^ $past(io_image_q[idx[5:0]])) & ~(8'h01 << $past(acc_bit))) == 8'h00) else $error("other bits moved");
  skip_hi_a: assert property (acc_valid && acc_kind == iob_pkg::IOB_SKIP_HIGH && lo
    |=> skip_q == $past(io_image_q[idx[5:0]][acc_bit])) else $error("skip high wrong");
  skip_lo_a: assert property (acc_valid && acc_kind == iob_pkg::IOB_SKIP_LOW && lo
    |=> skip_q == !$past(io_image_q[idx[5:0]][acc_bit])) else $error("skip low wrong");
  flag_clr_a: assert property (acc_valid && acc_kind == iob_pkg::IOB_WRITE && ok && idx == 7'h38
    && timer_flag_set == 8'h00 |=> io_image_q[56] == ($past(io_image_q[56]) & ~$past(acc_wdata)))
    else $error("flag write wrong");
  alias_rd_a: assert property (acc_valid && acc_kind == iob_pkg::IOB_READ && ok && pl
    |=> rd_data_q == $past(io_image_q[idx[5:0]])) else $error("read data wrong");
endmodule : iob_io_bank_chk

bind iob_io_bank iob_io_bank_chk #(.DATA_W(DATA_W)) u_chk (.clk(clk), .arst_n(arst_n), .acc_valid(acc_valid),
  .acc_kind(acc_kind), .acc_dspace(acc_dspace), .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata),
  .timer_flag_set(timer_flag_set), .resp_valid_q(resp_valid_q), .rd_data_q(rd_data_q), .skip_q(skip_q),
  .ignored_q(ignored_q), .io_image_q(io_image_q));

// file: testbench/iob_core_model.sv
// Core model: issues one I/O access at a time, returns the answer.
// Assumes the bank answers in the cycle after the taking edge.
`timescale 1ns/100ps
module iob_core_model (
  input  wire logic          clk,
  input  wire logic          resp_valid_q,
  input  wire logic [7:0]    rd_data_q,
  input  wire logic          skip_q,
  input  wire logic          ignored_q,
  output logic               acc_valid,
  output iob_pkg::iob_kind_e acc_kind,
  output logic               acc_dspace,
  output logic [6:0]         acc_addr,
  output logic [2:0]         acc_bit,
  output logic [7:0]         acc_wdata
);
  // Idle bus at time zero
  initial begin
    acc_valid = 1'b0;
    acc_kind = iob_pkg::IOB_READ;
    {acc_dspace, acc_addr, acc_bit, acc_wdata} = '0;
  end
  // Held over one taking edge; answer read a cycle later
  task automatic io_op(input iob_pkg::iob_kind_e k, input logic ds, input logic [6:0] a,
                       input logic [2:0] b, input logic [7:0] d, output logic [10:0] r);
    r = 11'h000;
    // Reserved slot is never written
    if (!(k == iob_pkg::IOB_WRITE && (ds ? a - 7'h20 : a) == 7'h3c)) begin
      @(negedge clk);
      acc_valid <= 1'b1;
      acc_kind <= k;
      {acc_dspace, acc_addr, acc_bit, acc_wdata} <= {ds, a, b, d};
      @(negedge clk);
      acc_valid <= 1'b0;
      r = {resp_valid_q, ignored_q, skip_q, rd_data_q};
    end
  endtask : io_op
endmodule : iob_core_model

// file: testbench/tb_top.sv
// Bench for the I/O bank: byte, bit, skip, flag and alias access.
// Assumes a 50 MHz clock and all registers zero after reset.
`timescale 1ns/100ps
module tb_top;
  logic clk, arst_n, resp, skp, ign, wdf;
  logic [7:0] rdd, pa, pb, tf;
  logic [2:0] ef;
  logic [6:0] ad;
  logic [2:0] bt;
  logic [7:0] wd;
  logic dsp, vld;
  iob_pkg::iob_kind_e kd;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;  // Hang guard
  localparam iob_pkg::iob_kind_e RD = iob_pkg::IOB_READ, WR = iob_pkg::IOB_WRITE;
  localparam iob_pkg::iob_kind_e SB = iob_pkg::IOB_SET_BIT, CB = iob_pkg::IOB_CLEAR_BIT;
  localparam iob_pkg::iob_kind_e SH = iob_pkg::IOB_SKIP_HIGH, SL = iob_pkg::IOB_SKIP_LOW;
  iob_core_model core (.clk(clk), .resp_valid_q(resp), .rd_data_q(rdd), .skip_q(skp), .ignored_q(ign),
    .acc_valid(vld), .acc_kind(kd), .acc_dspace(dsp), .acc_addr(ad), .acc_bit(bt), .acc_wdata(wd));
  iob_io_bank DUT (.clk(clk), .arst_n(arst_n), .acc_valid(vld), .acc_kind(kd), .acc_dspace(dsp),
    .acc_addr(ad), .acc_bit(bt), .acc_wdata(wd), .port_a_pins(pa), .port_b_pins(pb), .timer_flag_set(tf),
    .ext_flag_set(ef), .wdog_flag_set(wdf), .resp_valid_q(resp), .rd_data_q(rdd), .skip_q(skp),
    .ignored_q(ign), .io_image_q());
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Run far exceeds this only on a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      results();
    end
  end
  // Access then compare {resp, ignored, skip, data}
  task automatic io(input iob_pkg::iob_kind_e k, input logic ds, input logic [6:0] a, input logic [2:0] b,
                    input logic [7:0] d, input logic [10:0] e, input string w);
    logic [10:0] r;
    core.io_op(k, ds, a, b, d, r);
    samples_checked++;
    if (r !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", w, e, r);
    end
  endtask : io
  task automatic t_bytes();
    io(WR, 0, 7'h1b, 0, 8'h5a, 11'h400, "latch write");
    io(RD, 1, 7'h3b, 0, 0, 11'h45a, "alias read");
    io(WR, 1, 7'h3a, 0, 8'h3c, 11'h400, "alias write");
    io(RD, 0, 7'h1a, 0, 0, 11'h43c, "direction read");
    io(RD, 0, 7'h40, 0, 0, 11'h600, "outside space");
    io(RD, 0, 7'h3c, 0, 0, 11'h400, "unused slot");
  endtask : t_bytes
  task automatic t_bits();
    io(CB, 0, 7'h1b, 1, 0, 11'h45a, "clear bit");
    io(SB, 0, 7'h1b, 0, 0, 11'h458, "set bit");
    io(SH, 0, 7'h1b, 0, 0, 11'h559, "skip high");
    io(SL, 0, 7'h1b, 0, 0, 11'h459, "skip low");
    io(SL, 0, 7'h19, 2, 0, 11'h5c3, "pin skip low");
    io(RD, 1, 7'h36, 0, 0, 11'h496, "pin b alias read");
    io(SH, 0, 7'h16, 1, 0, 11'h596, "pin b skip high");
    io(SB, 1, 7'h3f, 0, 0, 11'h400, "top bit reg");
    io(RD, 0, 7'h1f, 0, 0, 11'h401, "top reg read");
    io(SB, 0, 7'h20, 0, 0, 11'h600, "bit op at 0x20");
    io(SH, 1, 7'h40, 0, 0, 11'h600, "skip at 0x20");
  endtask : t_bits
  task automatic t_flags();
    @(negedge clk);
    {tf, ef, wdf} = {8'hff, 3'b101, 1'b1};
    @(negedge clk);
    {tf, ef, wdf} = '0;
    io(WR, 0, 7'h38, 0, 8'h0f, 11'h4ff, "flag write one");
    io(WR, 0, 7'h38, 0, 8'h00, 11'h4f0, "flag write zero");
    io(RD, 0, 7'h38, 0, 0, 11'h4f0, "flags kept");
    io(WR, 0, 7'h3a, 0, 8'h20, 11'h4a0, "ext flag clear");
    io(RD, 0, 7'h3a, 0, 0, 11'h480, "ext flags");
    io(WR, 0, 7'h21, 0, 8'h80, 11'h480, "wdog flag clear");
    io(RD, 0, 7'h21, 0, 0, 11'h400, "wdog flag");
    io(SB, 0, 7'h38, 0, 0, 11'h600, "flag bit op");
  endtask : t_flags
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Reset ten cycles, then the scenarios
  initial begin
    {arst_n, pb, tf, ef, wdf} = '0;
    pa = 8'hc3;
    pb = 8'h96;  // Distinct from port A so a swapped pin map shows
    repeat (10) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_bytes();
    t_bits();
    t_flags();
    results();
  end
endmodule : tb_top
